// ---- cdt_pkg.sv ----
// constants, decode tables and types for the opcode decode and timing core
// assumes a single clock domain and a program memory that answers reads in one cycle
//
// Behaviour
// - multiply forms 16-bit unsigned index*accumulator, high byte index, one byte, 11 cycles
// - high nibble picks mode A,B,C,F,E,D with lengths 2,2,3,1,2,3 bytes
// - add-with-carry adds operand plus carry; arithmetic takes 2,3,4,3,4,5 cycles
// - low nibble 2 subtracts operand and borrow from accumulator, keeps difference
// - low nibble 8 exclusive-ors operand into the accumulator
// - low nibble 1 compares accumulator, nibble 3 compares index; flags only
// - low nibble 5 ands operand with accumulator for flags only
// - relative branches 20..2F are two bytes, 3 cycles; 20 always, 21 never
// - opcode 22 branches if unsigned higher, 23 if lower or same
// - opcode 24 branches on carry clear, 25 on carry set
// - opcode 28 branches on half-carry clear, 29 on half-carry set
// - opcode 2C branches on interrupt mask clear, 2D on mask set
// - opcode 2E branches when interrupt line low, 2F when high
// - relative call AD is two bytes, 6 cycles, pushes return address first
// - a branch whose condition fails acts as no-operation, continues sequentially
package cdt_pkg;

   // ==========================================================
   // addressing modes (opcode high nibble)
   localparam logic [3:0] MODE_IMM  = 4'ha;
   localparam logic [3:0] MODE_DIR  = 4'hb;
   localparam logic [3:0] MODE_EXT  = 4'hc;
   localparam logic [3:0] MODE_IX2  = 4'hd;
   localparam logic [3:0] MODE_IX1  = 4'he;
   localparam logic [3:0] MODE_IX   = 4'hf;
   localparam logic [3:0] MODE_REL  = 4'h2;

   // ==========================================================
   // register/memory functions (opcode low nibble)
   localparam logic [3:0] FN_SUB  = 4'h0;
   localparam logic [3:0] FN_CPA  = 4'h1;
   localparam logic [3:0] FN_SBW  = 4'h2;
   localparam logic [3:0] FN_CPI  = 4'h3;
   localparam logic [3:0] FN_AND  = 4'h4;
   localparam logic [3:0] FN_BIT  = 4'h5;
   localparam logic [3:0] FN_LDAC = 4'h6;
   localparam logic [3:0] FN_STAC = 4'h7;
   localparam logic [3:0] FN_XOR  = 4'h8;
   localparam logic [3:0] FN_ADC  = 4'h9;
   localparam logic [3:0] FN_ORA  = 4'ha;
   localparam logic [3:0] FN_ADD  = 4'hb;
   localparam logic [3:0] FN_JUMP = 4'hc;
   localparam logic [3:0] FN_CALL = 4'hd;
   localparam logic [3:0] FN_LDIX = 4'he;
   localparam logic [3:0] FN_STIX = 4'hf;

   // ==========================================================
   // branch conditions (low nibble of relative opcodes)
   localparam logic [3:0] BR_ALWAYS = 4'h0;
   localparam logic [3:0] BR_NEVER  = 4'h1;
   localparam logic [3:0] BR_HI     = 4'h2;
   localparam logic [3:0] BR_LS     = 4'h3;
   localparam logic [3:0] BR_CC     = 4'h4;
   localparam logic [3:0] BR_CS     = 4'h5;
   localparam logic [3:0] BR_NE     = 4'h6;
   localparam logic [3:0] BR_EQ     = 4'h7;
   localparam logic [3:0] BR_HCC    = 4'h8;
   localparam logic [3:0] BR_HCS    = 4'h9;
   localparam logic [3:0] BR_PL     = 4'ha;
   localparam logic [3:0] BR_MI     = 4'hb;
   localparam logic [3:0] BR_MC     = 4'hc;
   localparam logic [3:0] BR_MS     = 4'hd;
   localparam logic [3:0] BR_IL     = 4'he;

   // ==========================================================
   // special opcodes, cycle and byte figures
   localparam logic [7:0] OP_MULT   = 8'h42;
   localparam logic [7:0] OP_RCALL  = 8'had;
   localparam logic [3:0] CYC_MULT  = 4'hb;
   localparam logic [3:0] CYC_REL   = 4'h3;
   localparam logic [3:0] CYC_RCALL = 4'h6;
   localparam logic [3:0] CYC_BAD   = 4'h2;
   localparam logic [3:0] CYC_FIRST = 4'h1;
   localparam logic [3:0] CYC_STORE_EXTRA = 4'h1;
   localparam logic [3:0] CYC_JUMP_LESS   = 4'h1;
   localparam logic [3:0] CYC_CALL_EXTRA  = 4'h2;
   localparam logic [1:0] BYTES_ONE   = 2'h1;
   localparam logic [1:0] BYTES_TWO   = 2'h2;
   localparam logic [1:0] BYTES_THREE = 2'h3;

   // ==========================================================
   // stack: 6-bit pointer inside a fixed page, reset to top
   localparam logic [9:0]  STACK_PAGE  = 10'h003;
   localparam logic [5:0]  SP_RESET    = 6'h3f;
   localparam logic [15:0] PC_RESET    = 16'h0100;

   typedef enum {K_ALU, K_STORE, K_JUMP, K_CALL, K_BRANCH, K_RCALL, K_MULT, K_BAD} cdt_kind_e;

   // ==========================================================
   // decode helpers
   function automatic logic is_mem_mode(input logic [3:0] hi);
      return hi inside {MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX2, MODE_IX1, MODE_IX};
   endfunction

   function automatic cdt_kind_e dec_kind(input logic [7:0] op);
      if (op == OP_MULT)
         return K_MULT;
      if (op == OP_RCALL)
         return K_RCALL;
      if (op[7:4] == MODE_REL)
         return K_BRANCH;
      if (!is_mem_mode(op[7:4]))
         return K_BAD;
      if (op[3:0] == FN_STAC || op[3:0] == FN_STIX)
         return (op[7:4] == MODE_IMM) ? K_BAD : K_STORE;
      if (op[3:0] == FN_JUMP)
         return (op[7:4] == MODE_IMM) ? K_BAD : K_JUMP;
      if (op[3:0] == FN_CALL)
         return K_CALL;
      return K_ALU;
   endfunction

   // instruction length by addressing mode
   function automatic logic [1:0] dec_bytes(input logic [7:0] op);
      if (op[7:4] == MODE_REL || op == OP_RCALL)
         return BYTES_TWO;
      unique case (op[7:4])
         MODE_IMM, MODE_DIR, MODE_IX1: return BYTES_TWO;
         MODE_EXT, MODE_IX2:           return BYTES_THREE;
         default:                      return BYTES_ONE;
      endcase
   endfunction

   // arithmetic/load cycle count by mode
   function automatic logic [3:0] base_cycles(input logic [3:0] hi);
      unique case (hi)
         MODE_IMM:          return 4'h2;
         MODE_DIR, MODE_IX: return 4'h3;
         MODE_EXT, MODE_IX1: return 4'h4;
         default:           return 4'h5;
      endcase
   endfunction

   function automatic logic [3:0] dec_cycles(input logic [7:0] op);
      unique case (dec_kind(op))
         K_MULT:   return CYC_MULT;
         K_RCALL:  return CYC_RCALL;
         K_BRANCH: return CYC_REL;
         K_BAD:    return CYC_BAD;
         K_STORE:  return base_cycles(op[7:4]) + CYC_STORE_EXTRA;
         K_JUMP:   return base_cycles(op[7:4]) - CYC_JUMP_LESS;
         K_CALL:   return base_cycles(op[7:4]) + CYC_CALL_EXTRA;
         default:  return base_cycles(op[7:4]);
      endcase
   endfunction

endpackage

// ---- cdt_alu.sv ----
// combinational arithmetic and logic unit for the register/memory group and multiply
// assumes the sequencer registers everything it produces
`timescale 1ns/1ps
module cdt_alu
   import cdt_pkg::*;
(
   // operation select
   input  wire logic       mult,
   input  wire logic [3:0] fn,
   // operands and current flags
   input  wire logic [7:0] a,
   input  wire logic [7:0] x,
   input  wire logic [7:0] m,
   input  wire logic       h_in,
   input  wire logic       n_in,
   input  wire logic       z_in,
   input  wire logic       c_in,
   // results
   output logic [7:0]      res,
   output logic [7:0]      res_hi,
   output logic            wr_a,
   output logic            wr_x,
   output logic            h_out,
   output logic            n_out,
   output logic            z_out,
   output logic            c_out
);

   logic [8:0]  sum;
   logic [4:0]  half;
   logic [8:0]  diff;
   logic [15:0] prod;
   logic        cin;

   // =========================================================
   // datapath
   always_comb
   begin
      cin    = (fn == FN_ADC) ? c_in : 1'b0;
      sum    = {1'b0, a} + {1'b0, m} + {8'h00, cin};
      half   = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
      diff   = {1'b0, (fn == FN_CPI) ? x : a} - {1'b0, m} - {8'h00, (fn == FN_SBW) & c_in};
      prod   = {8'h00, a} * {8'h00, x};
      res    = a;
      res_hi = x;
      wr_a   = 1'b0;
      wr_x   = 1'b0;
      h_out  = h_in;
      n_out  = n_in;
      z_out  = z_in;
      c_out  = c_in;
      if (mult)
      begin
         res    = prod[7:0];
         res_hi = prod[15:8];
         wr_a   = 1'b1;
         wr_x   = 1'b1;
         h_out  = 1'b0;
         c_out  = 1'b0;
      end
      else
      begin
         unique case (fn)
            FN_ADD, FN_ADC:
            begin
               res   = sum[7:0];
               wr_a  = 1'b1;
               h_out = half[4];
               c_out = sum[8];
            end
            FN_SUB, FN_SBW, FN_CPA, FN_CPI:
            begin
               res   = diff[7:0];
               wr_a  = (fn == FN_SUB) || (fn == FN_SBW);
               c_out = diff[8];
            end
            FN_AND, FN_BIT:
            begin
               res  = a & m;
               wr_a = (fn == FN_AND);
            end
            FN_ORA:
            begin
               res  = a | m;
               wr_a = 1'b1;
            end
            FN_XOR:
            begin
               res  = a ^ m;
               wr_a = 1'b1;
            end
            FN_LDAC:
            begin
               res  = m;
               wr_a = 1'b1;
            end
            FN_LDIX:
            begin
               res  = m;
               wr_x = 1'b1;
            end
            FN_STAC:
               res = a;
            FN_STIX:
               res = x;
            default:
               res = a;
         endcase
         n_out = res[7];
         z_out = (res == 8'h00);
      end
   end

endmodule

// ---- cdt_core.sv ----
// instruction sequencer: fetches opcodes, walks each instruction for its exact cycle count
// assumes program memory returns read data on MEM_RDATA in the cycle MEM_RD stands high
`timescale 1ns/1ps
module cdt_core
   import cdt_pkg::*;
#(
   parameter logic [15:0] RESET_PC = PC_RESET
)
(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // program and data memory bus
   output logic [15:0]      MEM_ADDR,
   output logic             MEM_RD,
   output logic             MEM_WR,
   output logic [7:0]       MEM_WDATA,
   input  wire logic [7:0]  MEM_RDATA,
   // external interrupt line level
   input  wire logic        IRQ_LINE,
   // core state view
   output logic [7:0]       ACC,
   output logic [7:0]       IDX,
   output logic [4:0]       CCR,
   output logic [15:0]      PC_NOW,
   output logic             INSTR_DONE,
   output logic             BAD_OPCODE
);

   typedef enum {PH_BOOT, PH_RUN} cdt_phase_e;

   typedef struct packed {
      cdt_phase_e  phase;
      logic [15:0] pc;
      logic [7:0]  a;
      logic [7:0]  x;
      logic [5:0]  sp;
      logic        h;
      logic        i;
      logic        n;
      logic        z;
      logic        c;
      logic [7:0]  op;
      logic [15:0] ea;
      logic [7:0]  dat;
      logic [3:0]  cyc;
      logic [15:0] mem_addr;
      logic        mem_rd;
      logic        mem_wr;
      logic [7:0]  mem_wdata;
      logic        done;
      logic        bad;
   } cdt_state_s;

   cdt_state_s s;
   cdt_state_s next_s;

   logic       rst_meta;
   logic       rst_sync;

   logic [7:0]  opc;
   cdt_kind_e   kind;
   logic [1:0]  nbytes;
   logic [3:0]  total;
   logic [3:0]  ready;
   logic [7:0]  operand;
   logic [15:0] ea_now;
   logic [15:0] target;
   logic        take;

   logic [7:0]  alu_res;
   logic [7:0]  alu_hi;
   logic        alu_wr_a;
   logic        alu_wr_x;
   logic        alu_h;
   logic        alu_n;
   logic        alu_z;
   logic        alu_c;

   // =========================================================
   // reset release through two flops; the async edge only clears them
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // =========================================================
   // branch condition evaluation
   function automatic logic branch_taken(input logic [3:0] cond, input logic h, input logic i,
                                         input logic n, input logic z, input logic c,
                                         input logic line);
      logic t;
      unique case (cond[3:1])
         BR_ALWAYS[3:1]: t = 1'b1;
         BR_HI[3:1]:     t = !(c | z);
         BR_CC[3:1]:     t = !c;
         BR_NE[3:1]:     t = !z;
         BR_HCC[3:1]:    t = !h;
         BR_PL[3:1]:     t = !n;
         BR_MC[3:1]:     t = !i;
         BR_IL[3:1]:     t = !line;
         default:        t = 1'b0;
      endcase
      // odd condition codes are the inverse of the even ones
      return cond[0] ? !t : t;
   endfunction

   // =========================================================
   // execution unit
   cdt_alu u_alu (
      .mult   (kind == K_MULT),
      .fn     (opc[3:0]),
      .a      (s.a),
      .x      (s.x),
      .m      (operand),
      .h_in   (s.h),
      .n_in   (s.n),
      .z_in   (s.z),
      .c_in   (s.c),
      .res    (alu_res),
      .res_hi (alu_hi),
      .wr_a   (alu_wr_a),
      .wr_x   (alu_wr_x),
      .h_out  (alu_h),
      .n_out  (alu_n),
      .z_out  (alu_z),
      .c_out  (alu_c)
   );

   // =========================================================
   // decode of the current opcode; in cycle one it is still on the bus
   always_comb
   begin
      opc    = (s.cyc == CYC_FIRST) ? MEM_RDATA : s.op;
      kind   = dec_kind(opc);
      nbytes = dec_bytes(opc);
      total  = dec_cycles(opc);
      // cycle in which the effective address is complete; immediate and
      // relative operands ride on the byte fetch of cycle one
      ready  = (opc[7:4] == MODE_IMM || kind == K_BRANCH || kind == K_RCALL)
               ? CYC_FIRST : {2'b00, nbytes};
      // operand is live on the bus the cycle after its read, latched later
      operand = (s.cyc == ready + CYC_FIRST) ? MEM_RDATA : s.dat;
      ea_now  = (nbytes == BYTES_THREE) ? {s.ea[15:8], MEM_RDATA}
              : (nbytes == BYTES_TWO) ? {8'h00, MEM_RDATA} : 16'h0000;
      if (opc[7:4] inside {MODE_IX, MODE_IX1, MODE_IX2})
         ea_now = ea_now + {8'h00, s.x};
      take = branch_taken(opc[3:0], s.h, s.i, s.n, s.z, s.c, IRQ_LINE);
   end

   // =========================================================
   // sequencer: one pass per cycle, exec cycle also launches next fetch
   always_comb
   begin
      next_s        = s;
      next_s.mem_rd = 1'b0;
      next_s.mem_wr = 1'b0;
      next_s.done   = 1'b0;
      next_s.bad    = 1'b0;
      target        = s.pc;
      unique case (s.phase)
         PH_BOOT:
         begin
            next_s.mem_addr = RESET_PC;
            next_s.mem_rd   = 1'b1;
            next_s.pc       = RESET_PC + 16'h0001;
            next_s.cyc      = CYC_FIRST;
            next_s.phase    = PH_RUN;
         end
         PH_RUN:
         begin
            next_s.cyc = s.cyc + CYC_FIRST;
            if (s.cyc == CYC_FIRST)
            begin
               next_s.op  = MEM_RDATA;
               next_s.bad = (kind == K_BAD);
            end
            // remaining instruction bytes, one read per cycle
            if (s.cyc < {2'b00, nbytes})
            begin
               next_s.mem_addr = s.pc;
               next_s.mem_rd   = 1'b1;
               next_s.pc       = s.pc + 16'h0001;
            end
            // high address byte of a three byte form
            if (s.cyc == {2'b00, BYTES_TWO} && nbytes == BYTES_THREE)
               next_s.ea = {MEM_RDATA, 8'h00};
            // effective address: read operand or write store data
            if (s.cyc == ready && ready != CYC_FIRST - CYC_FIRST &&
                opc[7:4] != MODE_IMM && kind inside {K_ALU, K_STORE, K_JUMP, K_CALL})
            begin
               next_s.ea = ea_now;
               if (kind == K_ALU)
               begin
                  next_s.mem_addr = ea_now;
                  next_s.mem_rd   = 1'b1;
               end
               if (kind == K_STORE)
               begin
                  next_s.mem_addr  = ea_now;
                  next_s.mem_wr    = 1'b1;
                  next_s.mem_wdata = alu_res;
               end
            end
            if (s.cyc == ready + CYC_FIRST)
               next_s.dat = MEM_RDATA;
            // return address pushed low byte first, stack grows down
            if (kind == K_CALL || kind == K_RCALL)
            begin
               if (s.cyc == ready + CYC_FIRST || s.cyc == ready + CYC_FIRST + CYC_FIRST)
               begin
                  next_s.mem_addr  = {STACK_PAGE, s.sp};
                  next_s.mem_wr    = 1'b1;
                  next_s.mem_wdata = (s.cyc == ready + CYC_FIRST) ? s.pc[7:0] : s.pc[15:8];
                  next_s.sp        = s.sp - 6'h01;
               end
            end
            // last cycle: retire and fetch the next opcode
            if (s.cyc == total)
            begin
               unique case (kind)
                  K_ALU, K_MULT:
                  begin
                     if (alu_wr_a)
                        next_s.a = alu_res;
                     if (alu_wr_x)
                        next_s.x = (kind == K_MULT) ? alu_hi : alu_res;
                     next_s.h = alu_h;
                     next_s.n = alu_n;
                     next_s.z = alu_z;
                     next_s.c = alu_c;
                  end
                  K_STORE:
                  begin
                     next_s.n = alu_n;
                     next_s.z = alu_z;
                  end
                  K_JUMP, K_CALL:
                     target = (s.cyc == ready) ? ea_now : s.ea;
                  K_BRANCH:
                     if (take)
                        target = s.pc + {{8{operand[7]}}, operand};
                     else
                        target = s.pc;
                  K_RCALL:
                     target = s.pc + {{8{s.dat[7]}}, s.dat};
                  default:
                     target = s.pc;
               endcase
               next_s.mem_addr = target;
               next_s.mem_rd   = 1'b1;
               next_s.pc       = target + 16'h0001;
               next_s.cyc      = CYC_FIRST;
               next_s.done     = 1'b1;
            end
         end
      endcase
   end

   // =========================================================
   // state register; interrupt mask comes up set, as after a real reset
   always_ff @(posedge SYS_CLK or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         s       <= '0;
         s.phase <= PH_BOOT;
         s.sp    <= SP_RESET;
         s.i     <= 1'b1;
      end
      else
         s <= next_s;
   end

   // =========================================================
   // outputs straight from the state flops
   assign MEM_ADDR   = s.mem_addr;
   assign MEM_RD     = s.mem_rd;
   assign MEM_WR     = s.mem_wr;
   assign MEM_WDATA  = s.mem_wdata;
   assign ACC        = s.a;
   assign IDX        = s.x;
   assign CCR        = {s.h, s.i, s.n, s.z, s.c};
   assign PC_NOW     = s.pc;
   assign INSTR_DONE = s.done;
   assign BAD_OPCODE = s.bad;

endmodule

// ---- cdt_core_properties.sv ----
// checker for the opcode decode and timing core: cycle counts, results, branch targets
// assumes it is bound to cdt_core and sees only its ports
`timescale 1ns/1ps
module cdt_core_properties
   import cdt_pkg::*;
(
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RSTN,
   // memory bus
   input wire logic [15:0] MEM_ADDR,
   input wire logic        MEM_RD,
   input wire logic [7:0]  MEM_RDATA,
   // core state view
   input wire logic [7:0]  ACC,
   input wire logic [7:0]  IDX,
   input wire logic [4:0]  CCR,
   input wire logic        INSTR_DONE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   // ==========================================================
   // opcode cycle: the first read after reset, then every read that comes with a retire,
   // since the opcode is on the bus in the same cycle as its registered read
   logic booted;
   logic op_cyc;
   always_ff @(posedge SYS_CLK or negedge RSTN)
      if (!RSTN)
         booted <= 1'b0;
      else if (MEM_RD)
         booted <= 1'b1;
   assign op_cyc = MEM_RD && (INSTR_DONE || !booted);

   // ==========================================================
   // assertions; an instruction of N cycles retires N cycles after its opcode cycle
   a_mult_time: assert property (op_cyc && MEM_RDATA == OP_MULT |->
      ##1 !INSTR_DONE[*8] ##1 !INSTR_DONE[*2] ##1 INSTR_DONE)
      else $error("multiply length wrong");
   a_mult_prod: assert property (op_cyc && MEM_RDATA == OP_MULT |-> ##11
      {IDX, ACC} == 16'($past(IDX, 11)) * 16'($past(ACC, 11))) else $error("bad product");
   a_mult_flags: assert property (op_cyc && MEM_RDATA == OP_MULT |-> ##11
      CCR[4] == 1'b0 && CCR[0] == 1'b0 && CCR[3:1] == $past(CCR[3:1], 11))
      else $error("multiply flags wrong");
   a_branch_time: assert property (op_cyc && MEM_RDATA[7:4] == MODE_REL
      |-> ##1 !INSTR_DONE[*2] ##1 INSTR_DONE) else $error("branch length wrong");
   a_never_seq: assert property (op_cyc && MEM_RDATA == 8'h21 |->
      ##3 MEM_RD && MEM_ADDR == $past(MEM_ADDR, 3) + 16'h2) else $error("branch never moved");
   a_always_tgt: assert property (op_cyc && MEM_RDATA == 8'h20 |-> ##3
      MEM_RD && MEM_ADDR == $past(MEM_ADDR, 3) + 16'h2
      + {{8{$past(MEM_RDATA[7], 2)}}, $past(MEM_RDATA, 2)}) else $error("branch target wrong");
   a_rcall_time: assert property (op_cyc && MEM_RDATA == OP_RCALL |->
      ##1 !INSTR_DONE[*5] ##1 INSTR_DONE) else $error("relative call length wrong");
   a_adc_time: assert property (op_cyc && MEM_RDATA == 8'hd9 |->
      ##1 !INSTR_DONE[*4] ##1 INSTR_DONE) else $error("add with carry length wrong");
   a_compare_keep: assert property (op_cyc && MEM_RDATA inside {8'ha1, 8'ha5}
      |-> ##1 !INSTR_DONE ##1 INSTR_DONE && ACC == $past(ACC, 2))
      else $error("compare wrote accumulator");

   // ==========================================================
   // covers
   c_mult: cover property (op_cyc && MEM_RDATA == OP_MULT);
   c_rcall: cover property (op_cyc && MEM_RDATA == OP_RCALL);
   c_never: cover property (op_cyc && MEM_RDATA == 8'h21);
endmodule

bind cdt_core cdt_core_properties cdt_core_properties_i (.SYS_CLK, .RSTN, .MEM_ADDR,
   .MEM_RD, .MEM_RDATA, .ACC, .IDX, .CCR, .INSTR_DONE);

// ---- cdt_mem_model.sv ----
// program and data memory answering every read in the cycle its request stands
// assumes one clock; the bench preloads program bytes while the core is held in reset
`timescale 1ns/1ps
module cdt_mem_model
(
   // bus from the core
   input  wire logic        clk,
   input  wire logic [15:0] addr,
   input  wire logic        rd,
   input  wire logic        wr,
   input  wire logic [7:0]  wdata,
   output logic [7:0]       rdata
);
   logic [7:0] mem [0:65535];

   // ==========================================================
   // writes land on the clock edge; the bench also preloads this array
   always @(posedge clk)
   begin
      if (wr)
         mem[addr] <= wdata;
   end

   // the core decodes read data while its registered request stands;
   // outside a read the lines flip, so a stale byte cannot pass for data
   assign rdata = rd ? mem[addr] : ~mem[addr];
endmodule

// ---- testbench.sv ----
// self-checking bench: short programs run from 0100h, results read from core and memory
// assumes cdt_core with its bound checker and the memory model
`timescale 1ns/1ps
module testbench;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        irq_line = 1'b0;
   logic [15:0] mem_addr;
   logic        mem_rd;
   logic        mem_wr;
   logic        done;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [7:0]  acc;
   logic [7:0]  idx;
   logic [4:0]  ccr;
   int          error_cnt = 0;
   int          n_compared = 0;

   // ==========================================================
   // clock, design and memory
   always #2.5 sys_clk = ~sys_clk;

   cdt_core cdt_core_i (.SYS_CLK(sys_clk), .RSTN(rstn), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
      .MEM_WR(mem_wr), .MEM_WDATA(wdata), .MEM_RDATA(rdata), .IRQ_LINE(irq_line), .ACC(acc),
      .IDX(idx), .CCR(ccr), .PC_NOW(), .INSTR_DONE(done), .BAD_OPCODE());
   cdt_mem_model cdt_mem_model_i (.clk(sys_clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr),
      .wdata(wdata), .rdata(rdata));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // reset 4 cycles, load the program, let it settle in its closing self-loop
   task automatic run(input logic [7:0] p [$]);
      rstn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      foreach (p[i])
         cdt_mem_model_i.mem[16'h0100 + 16'(i)] = p[i];
      rstn <= 1'b1;
      repeat (80) @(posedge sys_clk);
   endtask

   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   // carry is set by a failing compare first, so the multiply must clear it
   task automatic t_mult;
      run('{8'ha6, 8'h07, 8'ha1, 8'h08, 8'hae, 8'h25, 8'h42, 8'h20, 8'hfe});
      check({idx, acc}, 16'h0103);
      check({14'h0, ccr[4], ccr[0]}, 16'h0000);
   endtask

   // exclusive-or, compare, bit test, subtract with borrow, adc at 16-bit offset, store
   task automatic t_alu;
      cdt_mem_model_i.mem[16'h0200] = 8'h05;
      run('{8'ha6, 8'h0f, 8'ha8, 8'hff, 8'ha1, 8'h00, 8'ha5, 8'hff, 8'ha2, 8'h10,
            8'hae, 8'h00, 8'hd9, 8'h02, 8'h00, 8'hb7, 8'h80, 8'h20, 8'hfe});
      check({8'h0, acc}, 16'h00e5);
      check({8'h0, cdt_mem_model_i.mem[16'h0080]}, 16'h00e5);
   endtask

   // relative call: return address 0102h pushed low byte first
   task automatic t_rcall;
      run('{8'had, 8'h02, 8'h20, 8'hfe, 8'ha6, 8'h33, 8'h20, 8'hfe});
      check({8'h0, acc}, 16'h0033);
      check({cdt_mem_model_i.mem[16'h00fe], cdt_mem_model_i.mem[16'h00ff]}, 16'h0102);
   endtask

   // flags after a zero load: Z=1 N=0 C=0 H=0 I=1; taken branch skips a load of 01h
   task automatic t_branch;
      logic [9:0] cases [14] = '{10'h120, 10'h021, 10'h022, 10'h123, 10'h124, 10'h025,
         10'h128, 10'h029, 10'h02c, 10'h12d, 10'h12e, 10'h02f, 10'h22e, 10'h32f};
      foreach (cases[i])
      begin
         irq_line <= cases[i][9];
         run('{8'ha6, 8'h00, cases[i][7:0], 8'h02, 8'ha6, 8'h01, 8'h20, 8'hfe});
         check({8'h0, acc}, {15'h0, ~cases[i][8]});
      end
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      t_mult;
      t_alu;
      t_rcall;
      t_branch;
      finish_test;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      finish_test;
   end
endmodule
